// [hw/rtc_flags_pkg.sv]
// Constants and carrier types for the RTC flags and control register
package rtc_flags_pkg;

	// Clock and register placement
	localparam int        CLK_PERIOD_NS     = 10;
	localparam logic [7:0] FLAGS_OFFSET     = 8'h00;

	// Bit positions inside the flags and control register
	localparam int DOG_BIT    = 7;
	localparam int ALARM_BIT  = 6;
	localparam int DROP_BIT   = 5;
	localparam int XTAL_BIT   = 4;
	localparam int CAL_BIT    = 2;
	localparam int WRITE_BIT  = 1;
	localparam int READ_BIT   = 0;

	// Times in their own units and derived cycle counts
	localparam int OSC_WINDOW_MS        = 5;
	localparam int OSC_WINDOW_CYCLES    = OSC_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CAL_FREQ_HZ          = 512;
	localparam int CAL_HALF_CYCLES      = 1000000000 / (CLK_PERIOD_NS * CAL_FREQ_HZ * 2);
	localparam int CLEAR_SETTLE_TIME_NS = 1000;
	localparam int CLEAR_SETTLE_CYCLES  = (CLEAR_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Counter widths
	localparam int WIN_W    = 20;
	localparam int CALCNT_W = 17;
	localparam int SETTLE_W = 8;

	// Values after reset
	localparam logic       CAL_RESET   = 1'b0;
	localparam logic       WRITE_RESET = 1'b0;
	localparam logic       READ_RESET  = 1'b0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Event pulses from the watchdog, alarm comparator and supply monitor
	typedef struct packed {
		logic dog_zero;
		logic alarm_hit;
		logic supply_drop;
	} rtc_event_type;

	// Host access strobes to the register
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} reg_req_type;

endpackage : rtc_flags_pkg

// [hw/rtc_flags_control_reg.sv]
// Flags and control register of the real time clock
`timescale 1ns/1ns
module rtc_flags_control_reg #(
	parameter logic [19:0]   OSC_WINDOW = 20'(rtc_flags_pkg::OSC_WINDOW_CYCLES),
	parameter logic [16:0]   CAL_HALF   = 17'(rtc_flags_pkg::CAL_HALF_CYCLES)
) (
	// Clock and power-up reset
	input  wire logic                        MCLK,
	input  wire logic                        RESETN,
	// Register access from the serial host interface
	input  wire rtc_flags_pkg::reg_req_type  REG_REQ,
	output logic      [7:0]                  REG_RDATA,
	// Events from the time keeping logic
	input  wire rtc_flags_pkg::rtc_event_type EVENTS,
	input  wire logic                        OSC_ENABLED,
	input  wire logic                        OSC_RUNNING,
	input  wire logic                        XTAL_STOPPED_KEPT,
	input  wire logic                        INT_NORMAL,
	// Controls to the rest of the clock
	output logic                             INT_OUT,
	output logic                             HOLD_USER_REGS,
	output logic                             LOAD_COUNTERS,
	output logic                             FREEZE_SNAPSHOT,
	output logic                             XTAL_STOPPED_FLAG
);

	typedef struct packed {
		logic                                 dog_expired_flag;
		logic                                 alarm_hit_flag;
		logic                                 supply_drop_flag;
		logic                                 xtal_stopped_flag;
		logic                                 cal_q;
		logic                                 wr_q;
		logic                                 rd_q;
		logic [2:0]                           pend;
		logic                                 settle_busy;
		logic [rtc_flags_pkg::SETTLE_W-1:0]   settle_cnt;
		logic [rtc_flags_pkg::WIN_W-1:0]      win_cnt;
		logic                                 win_done;
		logic                                 osc_seen;
		logic [rtc_flags_pkg::CALCNT_W-1:0]   cal_cnt;
		logic                                 cal_wave;
		logic                                 int_out;
		logic                                 load_pulse;
		logic [7:0]                           rdata;
		logic                                 osc_s1;
		logic                                 osc_s2;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic      wr_hit;
	logic      rd_hit;
	logic [2:0] ev;

	assign wr_hit = REG_REQ.wr && (REG_REQ.addr == rtc_flags_pkg::FLAGS_OFFSET);
	assign rd_hit = REG_REQ.rd && (REG_REQ.addr == rtc_flags_pkg::FLAGS_OFFSET);
	assign ev     = {EVENTS.dog_zero, EVENTS.alarm_hit, EVENTS.supply_drop};

	// Next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.osc_s1 = OSC_RUNNING;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.load_pulse = 1'b0;
		// Reads capture the old value, then clear the event flags
		if (rd_hit) begin
			s_d.rdata = {s_q.dog_expired_flag, s_q.alarm_hit_flag, s_q.supply_drop_flag,
				s_q.xtal_stopped_flag, 1'b0, s_q.cal_q, s_q.wr_q, s_q.rd_q};
			s_d.dog_expired_flag = 1'b0;
			s_d.alarm_hit_flag   = 1'b0;
			s_d.supply_drop_flag = 1'b0;
		end else if (REG_REQ.rd) begin
			s_d.rdata = 8'h00; // Unmapped address reads zero
		end
		// Host writes: control bits stored, event flags read only, a zero to the oscillator flag starts its clear
		if (wr_hit) begin
			s_d.cal_q = REG_REQ.wdata[rtc_flags_pkg::CAL_BIT];
			s_d.wr_q  = REG_REQ.wdata[rtc_flags_pkg::WRITE_BIT];
			s_d.rd_q  = REG_REQ.wdata[rtc_flags_pkg::READ_BIT];
			if (s_q.wr_q && !REG_REQ.wdata[rtc_flags_pkg::WRITE_BIT]) begin
				s_d.load_pulse = 1'b1;
			end
			// A zero written to the oscillator flag only starts the settle timer
			if (!REG_REQ.wdata[rtc_flags_pkg::XTAL_BIT] && s_q.xtal_stopped_flag && !s_q.settle_busy) begin
				s_d.settle_busy = 1'b1;
				s_d.settle_cnt  = rtc_flags_pkg::SETTLE_W'(rtc_flags_pkg::CLEAR_SETTLE_CYCLES);
			end
		end
		// Settle countdown; the only path that clears the oscillator flag
		if (s_q.settle_busy) begin
			if (s_q.settle_cnt == 8'h01) begin
				s_d.settle_busy       = 1'b0;
				s_d.xtal_stopped_flag = 1'b0;
			end else begin
				s_d.settle_cnt = s_q.settle_cnt - 8'h01;
			end
		end
		// Events park while the write bit holds the register; set wins over read clear
		if (s_q.wr_q) begin
			s_d.pend = s_q.pend | ev;
		end else begin
			s_d.pend = 3'h0;
			if (ev[2] || s_q.pend[2]) begin
				s_d.dog_expired_flag = 1'b1;
			end
			if (ev[1] || s_q.pend[1]) begin
				s_d.alarm_hit_flag = 1'b1;
			end
			if (ev[0] || s_q.pend[0]) begin
				s_d.supply_drop_flag = 1'b1;
			end
		end
		// Oscillator watch window after power-up; set wins over the settle clear
		if (!s_q.win_done) begin
			if (s_q.osc_s2) begin
				s_d.osc_seen = 1'b1;
			end
			s_d.win_cnt = s_q.win_cnt + 20'h0_0001;
			if (s_q.win_cnt == OSC_WINDOW - 20'h0_0001) begin
				s_d.win_done = 1'b1;
				if (OSC_ENABLED && !s_q.osc_seen && !s_q.osc_s2) begin
					s_d.xtal_stopped_flag = 1'b1;
				end
			end
		end
		// Calibration square wave, toggled every half period
		if (s_q.cal_q) begin
			if (s_q.cal_cnt == CAL_HALF - 17'h0_0001) begin
				s_d.cal_cnt  = 17'h0_0000;
				s_d.cal_wave = !s_q.cal_wave;
			end else begin
				s_d.cal_cnt = s_q.cal_cnt + 17'h0_0001;
			end
		end else begin
			s_d.cal_cnt  = 17'h0_0000;
			s_d.cal_wave = 1'b0;
		end
		// Pin shows the wave in calibration mode, the interrupt otherwise
		s_d.int_out = s_q.cal_q ? s_q.cal_wave : INT_NORMAL;
	end

	// State register; the oscillator flag reloads its retained copy at power-up
	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			s_q                   <= '0;
			s_q.cal_q             <= rtc_flags_pkg::CAL_RESET;
			s_q.wr_q              <= rtc_flags_pkg::WRITE_RESET;
			s_q.rd_q              <= rtc_flags_pkg::READ_RESET;
			s_q.rdata             <= rtc_flags_pkg::RDATA_RESET;
			s_q.xtal_stopped_flag <= XTAL_STOPPED_KEPT;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs all come from flip-flops
	assign REG_RDATA         = s_q.rdata;
	assign INT_OUT           = s_q.int_out;
	assign HOLD_USER_REGS    = s_q.wr_q;
	assign LOAD_COUNTERS     = s_q.load_pulse;
	assign FREEZE_SNAPSHOT   = s_q.rd_q;
	assign XTAL_STOPPED_FLAG = s_q.xtal_stopped_flag;

	// Checks next to the logic they guard
	AST_DOG_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
		EVENTS.dog_zero && !s_q.wr_q |=> s_q.dog_expired_flag)
		else $error("watchdog flag not set");
	AST_DOG_READ_CLEAR: assert property (@(posedge MCLK) disable iff (!RESETN)
		rd_hit && !EVENTS.dog_zero && !s_q.pend[2] |=> !s_q.dog_expired_flag && REG_RDATA[7] == $past(s_q.dog_expired_flag))
		else $error("watchdog flag read clear wrong");
	AST_ALARM_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
		EVENTS.alarm_hit && !s_q.wr_q |=> s_q.alarm_hit_flag)
		else $error("alarm flag not set");
	AST_XTAL_WINDOW: assert property (@(posedge MCLK) disable iff (!RESETN)
		$rose(s_q.win_done) && !$past(s_q.osc_seen) && !$past(s_q.osc_s2) && $past(OSC_ENABLED) |-> s_q.xtal_stopped_flag)
		else $error("oscillator fail flag not set after window");
	AST_XTAL_NO_SELF_CLEAR: assert property (@(posedge MCLK) disable iff (!RESETN)
		$fell(s_q.xtal_stopped_flag) |-> $past(s_q.settle_busy) && $past(s_q.settle_cnt) == 8'h01)
		else $error("oscillator flag cleared without settle");
	AST_XTAL_SETTLE: assert property (@(posedge MCLK) disable iff (!RESETN)
		wr_hit && !REG_REQ.wdata[4] && s_q.xtal_stopped_flag && !s_q.settle_busy |=> s_q.xtal_stopped_flag [*8])
		else $error("oscillator flag cleared too early");
	AST_CAL_TOGGLE: assert property (@(posedge MCLK) disable iff (!RESETN)
		s_q.cal_q && $past(s_q.cal_q) && s_q.cal_cnt == 17'h0_0000 |-> $changed(s_q.cal_wave))
		else $error("calibration wave did not toggle");
	AST_INT_NORMAL: assert property (@(posedge MCLK) disable iff (!RESETN)
		!s_q.cal_q |=> INT_OUT == $past(INT_NORMAL))
		else $error("interrupt pin not normal");
	AST_CAL_RESET: assert property (@(posedge MCLK) disable iff (!RESETN)
		$rose(RESETN) |-> !s_q.cal_q && !s_q.wr_q && !s_q.rd_q)
		else $error("control bits not zero after power-up");
	AST_LOAD: assert property (@(posedge MCLK) disable iff (!RESETN)
		wr_hit && s_q.wr_q && !REG_REQ.wdata[1] |=> LOAD_COUNTERS ##1 !LOAD_COUNTERS)
		else $error("counter load pulse missing");
	AST_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN)
		s_q.wr_q && !s_q.dog_expired_flag && !rd_hit && !wr_hit |=> !s_q.dog_expired_flag)
		else $error("flag updated while write bit held");
	AST_FREEZE: assert property (@(posedge MCLK) disable iff (!RESETN)
		wr_hit |=> FREEZE_SNAPSHOT == $past(REG_REQ.wdata[0]))
		else $error("snapshot control wrong");

	COV_READ_CLEAR: cover property (@(posedge MCLK) disable iff (!RESETN)
		s_q.dog_expired_flag && rd_hit ##1 !s_q.dog_expired_flag);
	COV_XTAL_CLEAR: cover property (@(posedge MCLK) disable iff (!RESETN)
		$fell(s_q.xtal_stopped_flag));
	COV_CAL: cover property (@(posedge MCLK) disable iff (!RESETN)
		s_q.cal_q && $changed(s_q.cal_wave));
	COV_LOAD: cover property (@(posedge MCLK) disable iff (!RESETN)
		LOAD_COUNTERS);

endmodule : rtc_flags_control_reg

// [verif/rtc_host_model.sv]
// Host side model that issues single-byte accesses to the flags register
`timescale 1ns/1ns
module rtc_host_model (
	// Clock
	input  wire logic                  MCLK,
	// Request toward the register
	output rtc_flags_pkg::reg_req_type REG_REQ
);
	logic [7:0] last_q;

	initial begin
		REG_REQ = '0;
		last_q  = 8'h00;
	end

	// One strobe cycle launched after an edge; idle lines carry inverted junk so stale data never looks valid
	task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data);
		@(posedge MCLK);
		#1;
		REG_REQ = '{addr: addr, wr: wr, rd: ~wr, wdata: data};
		last_q  = data;
		@(posedge MCLK);
		#1;
		REG_REQ = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~last_q};
	endtask : access
endmodule : rtc_host_model

// [verif/test_rtc_flags_control_reg.sv]
// Self-checking bench for the flags and control register
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD %s expected %h seen %h", what, exp, got); end end
module test_rtc_flags_control_reg;
	logic                         mclk;
	logic                         resetn;
	rtc_flags_pkg::reg_req_type   reg_req;
	logic [7:0]                   reg_rdata;
	rtc_flags_pkg::rtc_event_type events;
	logic                         int_normal;
	logic                         int_out;
	logic                         hold_user_regs;
	logic                         load_counters;
	logic                         freeze_snapshot;
	logic                         xtal_stopped_flag;
	logic [7:0]                   exp_q[$];
	logic                         rd_seen;
	logic                         prev;
	logic [7:0]                   exp_v;
	logic                         xtal_kept;
	logic                         osc_running;
	logic                         osc_enabled;
	int                           n_errors;
	int                           n_compared;
	integer                       seed;

	rtc_host_model rtc_host_model_i (.MCLK(mclk), .REG_REQ(reg_req));
	rtc_flags_control_reg #(.OSC_WINDOW(20'h0_0032), .CAL_HALF(17'h0_0004)) rtc_flags_control_reg_i (
		.MCLK(mclk), .RESETN(resetn), .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .EVENTS(events),
		.OSC_ENABLED(osc_enabled), .OSC_RUNNING(osc_running), .XTAL_STOPPED_KEPT(xtal_kept),
		.INT_NORMAL(int_normal),
		.INT_OUT(int_out), .HOLD_USER_REGS(hold_user_regs), .LOAD_COUNTERS(load_counters),
		.FREEZE_SNAPSHOT(freeze_snapshot), .XTAL_STOPPED_FLAG(xtal_stopped_flag));

	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Read data shows one cycle after the taken edge; compare it with the oldest note
	initial rd_seen = 1'b0;
	always @(posedge mclk) begin
		if (rd_seen) begin
			// Pop once: the macro names its expected value twice
			exp_v = exp_q.pop_front();
			`CHECK("read data", exp_v, reg_rdata)
		end
		rd_seen = reg_req.rd;
	end

	// Random interrupt level changes just after each edge
	always @(posedge mclk) begin
		#1;
		int_normal = 1'($random(seed));
	end

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		exp_q.push_back(exp);
		rtc_host_model_i.access(addr, 1'b0, 8'h00);
	endtask : rd

	task automatic wr(input logic [7:0] data);
		rtc_host_model_i.access(rtc_flags_pkg::FLAGS_OFFSET, 1'b1, data);
	endtask : wr

	task automatic pulse(input rtc_flags_pkg::rtc_event_type ev);
		@(posedge mclk);
		#1;
		events = ev;
		@(posedge mclk);
		#1;
		events = '0;
	endtask : pulse

	task automatic final_report();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// Watchdog against a hung run
	initial begin
		#300000;
		n_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		seed = 32'habbb_f0e3;
		n_errors = 0;
		n_compared = 0;
		resetn = 1'b0;
		events = '0;
		int_normal = 1'b0;
		xtal_kept = 1'b0;
		osc_running = 1'b0;
		osc_enabled = 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		resetn = 1'b1;
		rd(8'h00, 8'h00);
		repeat (60) @(posedge mclk);
		rd(8'h00, 8'h10);
		`CHECK("xtal flag", 1'b1, xtal_stopped_flag)
		for (int i = 0; i < 3; i++) pulse(3'b100 >> i);
		rd(8'h05, 8'h00);
		rd(8'h00, 8'hf0);
		rd(8'h00, 8'h10);
		wr(8'h00);
		rd(8'h00, 8'h10);
		repeat (100) @(posedge mclk);
		rd(8'h00, 8'h00);
		wr(8'h02);
		`CHECK("hold", 1'b1, hold_user_regs)
		pulse(3'b100);
		rd(8'h00, 8'h02);
		wr(8'h00);
		`CHECK("load", 1'b1, load_counters)
		`CHECK("hold off", 1'b0, hold_user_regs)
		rd(8'h00, 8'h80);
		wr(8'h01);
		`CHECK("freeze", 1'b1, freeze_snapshot)
		rd(8'h00, 8'h01);
		wr(8'h04);
		// Wave starts low, so lock onto its first rise before counting half periods
		// The pin still shows the stale interrupt level for one cycle, so let it pass first
		@(posedge mclk);
		#2;
		for (int i = 0; i < 20 && int_out !== 1'b1; i++) begin
			@(posedge mclk);
			#2;
		end
		prev = 1'b1;
		for (int i = 0; i < 4; i++) begin
			repeat (4) @(posedge mclk);
			#2;
			prev = ~prev;
			`CHECK("cal wave", prev, int_out)
		end
		wr(8'h00);
		repeat (2) @(posedge mclk);
		#2;
		for (int i = 0; i < 10; i++) begin
			prev = int_normal;
			@(posedge mclk);
			#2;
			`CHECK("int follow", prev, int_out)
		end
		// Further power-ups: retained flag, running oscillator, disabled oscillator
		for (int k = 2; k >= 0; k--) begin
			@(posedge mclk);
			#1;
			resetn      = 1'b0;
			xtal_kept   = (k == 2);
			osc_running = (k != 0);
			osc_enabled = (k != 0);
			repeat (10) @(posedge mclk);
			#1;
			resetn = 1'b1;
			`CHECK("xtal kept", xtal_kept, xtal_stopped_flag)
			repeat (60) @(posedge mclk);
			rd(8'h00, {3'h0, xtal_kept, 4'h0});
		end
		repeat (3) @(posedge mclk);
		`CHECK("queue left", 0, exp_q.size())
		final_report();
	end
endmodule : test_rtc_flags_control_reg
